/* File: design/pec_divider.sv */
// Sequential restoring divider shared by the postprocessing pass
`timescale 1ns/1ps
module pec_divider #(
  parameter int NW = 64,
  parameter int DW = 48
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire logic [NW-1:0] dividend_i,
  input wire logic [DW-1:0] divisor_i,
  output logic done_o,
  output logic [NW-1:0] quotient_o
);

  localparam int CW = $clog2(NW+1);

  typedef struct packed {
    logic [NW-1:0] q;
    logic [DW-1:0] r;
    logic [DW-1:0] d;
    logic [CW-1:0] cnt;
    logic busy;
    logic done;
  } pec_div_t;

  pec_div_t st_q;
  pec_div_t st_d;
  logic [DW:0] shifted;

  // ------------------------------------------------------------
  // One quotient bit per cycle; zero divisor yields all ones
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    shifted = {st_q.r, st_q.q[NW-1]};
    if (start_i) begin
      st_d.q = dividend_i;
      st_d.r = '0;
      st_d.d = divisor_i;
      st_d.cnt = CW'(NW);
      st_d.busy = 1'b1;
    end else if (st_q.busy) begin
      if (shifted >= {1'b0, st_q.d}) begin
        st_d.r = DW'(shifted - {1'b0, st_q.d});
        st_d.q = {st_q.q[NW-2:0], 1'b1};
      end else begin
        st_d.r = shifted[DW-1:0];
        st_d.q = {st_q.q[NW-2:0], 1'b0};
      end
      st_d.cnt = st_q.cnt - 1'b1;
      st_d.busy = (st_q.cnt != CW'(1));
      st_d.done = (st_q.cnt == CW'(1));
    end
  end

  // Frozen with the block when the clock enable is low
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_q <= '0;
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

  assign done_o = st_q.done;
  assign quotient_o = st_q.q;

endmodule : pec_divider

/* File: design/pec_energy_compute.sv */
// Polyphase energy accumulation, postprocessing and on-demand display values
`timescale 1ns/1ps
module pec_energy_compute (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic frame_valid_i,
  input wire logic signed [pec_pkg::SAMPLE_W-1:0] va_i,
  input wire logic signed [pec_pkg::SAMPLE_W-1:0] vb_i,
  input wire logic signed [pec_pkg::SAMPLE_W-1:0] vc_i,
  input wire logic signed [pec_pkg::SAMPLE_W-1:0] ia_i,
  input wire logic signed [pec_pkg::SAMPLE_W-1:0] ib_i,
  input wire logic signed [pec_pkg::SAMPLE_W-1:0] ic_i,
  input wire logic [1:0] phase_b_connection_field_i,
  input wire logic [pec_pkg::NS_W-1:0] cycle_length_frames_a_i,
  input wire logic [pec_pkg::NS_W-1:0] cycle_length_frames_b_i,
  input wire logic [pec_pkg::NS_W-1:0] cycle_length_frames_c_i,
  input wire logic [pec_pkg::CYC_W-1:0] line_cycles_per_dsp_cycle_i,
  input wire logic [pec_pkg::RMS_W-1:0] phase_rms_voltage_a_i,
  input wire logic [pec_pkg::RMS_W-1:0] phase_rms_voltage_b_i,
  input wire logic [pec_pkg::RMS_W-1:0] phase_rms_voltage_c_i,
  input wire logic [pec_pkg::RMS_W-1:0] phase_rms_current_a_i,
  input wire logic [pec_pkg::RMS_W-1:0] phase_rms_current_b_i,
  input wire logic [pec_pkg::RMS_W-1:0] phase_rms_current_c_i,
  input wire logic [pec_pkg::NO_LOAD_THRESHOLD_W-1:0] no_load_threshold_i,
  input wire logic [pec_pkg::CC_W-1:0] voltage_conversion_constant_i,
  input wire logic [pec_pkg::CC_W-1:0] current_conversion_constant_i,
  input wire logic [pec_pkg::CC_W-1:0] power_conversion_constant_i,
  input wire logic acc_delay_wr_i,
  input wire logic [pec_pkg::DELAY_W-1:0] acc_delay_wdata_i,
  input wire logic disp_req_i,
  input wire logic [pec_pkg::SEL_W-1:0] disp_sel_i,
  input wire logic [pec_pkg::LEN_W-1:0] disp_len_i,
  output logic [pec_pkg::DELAY_W-1:0] accumulation_delay_count_o,
  output logic pulse_enable_o,
  output logic postproc_busy_o,
  output logic dsp_cycle_done_o,
  output logic disp_valid_o,
  output logic [pec_pkg::DATA_W-1:0] disp_data_o,
  output logic [pec_pkg::ENERGY_W-1:0] active_energy_a_o,
  output logic [pec_pkg::ENERGY_W-1:0] active_energy_b_o,
  output logic [pec_pkg::ENERGY_W-1:0] active_energy_c_o
);
  import pec_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {PP_IDLE, PP_PREP, PP_START, PP_WAIT, PP_DONE} pec_pp_t;

  typedef struct packed {
    logic [NS_W:0] pos;
    logic [2:0][ENERGY_W-1:0] acc;
    logic [2:0][ENERGY_W-1:0] sav;
    logic [2:0][ENERGY_W-1:0] app;
    logic [2:0][ENERGY_W-1:0] tot;
    logic [2:0][RMS_W-1:0] vr;
    logic [2:0][RMS_W-1:0] ir;
    logic [2:0][RMS_W-1:0] vr_pub;
    logic [2:0][RMS_W-1:0] ir_pub;
    logic [NS_W-1:0] ns;
    logic [RES_COUNT-1:0][RESULT_W-1:0] work;
    logic [RES_COUNT-1:0][RESULT_W-1:0] pub;
    pec_pp_t pp;
    logic [3:0] k;
    logic [DELAY_W-1:0] delay;
    logic discard;
    logic pulse_en;
    logic busy;
    logic done;
    logic dvalid;
    logic div_start;
    logic [DATA_W-1:0] dout;
  } pec_state_t;

  pec_state_t st_q;
  pec_state_t st_d;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Index modulo three: result slot or display select to phase
  function automatic logic [1:0] phase_of(input logic [3:0] idx);
    logic [3:0] t;
    t = idx;
    for (int i = 0; i < 5; i++) begin
      if (t >= 4'h3) begin
        t = t - 4'h3;
      end
    end
    return t[1:0];
  endfunction : phase_of

  function automatic logic [ENERGY_W-1:0] mag(input logic [ENERGY_W-1:0] e);
    return e[ENERGY_W-1] ? ENERGY_W'(-e) : e;
  endfunction : mag

  // Keeps only the requested number of low bytes; length 0 keeps all eight
  function automatic logic [DATA_W-1:0] len_mask(input logic [LEN_W-1:0] len);
    if (len == '0 || len >= BYTES_FULL) begin
      return '1;
    end
    return ~({DATA_W{1'b1}} << {len, 3'b000});
  endfunction : len_mask

  function automatic logic signed [ENERGY_W-1:0] pb_prod(
    input logic [1:0] conn,
    input logic signed [SAMPLE_W-1:0] ib,
    input logic signed [SAMPLE_W-1:0] vb,
    input logic signed [SAMPLE_W-1:0] va,
    input logic signed [SAMPLE_W-1:0] vc
  );
    logic signed [SAMPLE_W:0] s;
    logic signed [SAMPLE_W:0] d;
    // Sign-extend before adding and widen before multiplying
    s = (SAMPLE_W+1)'(va) + (SAMPLE_W+1)'(vc);
    d = (SAMPLE_W+1)'(va) - (SAMPLE_W+1)'(vc);
    case (conn)
      CONN_VB: return ENERGY_W'(ib) * ENERGY_W'(vb);
      CONN_NEG_VC: return -(ENERGY_W'(ib) * ENERGY_W'(vc));
      CONN_NEG_SUM: return -(ENERGY_W'(ib) * ENERGY_W'(s));
      default: return -(ENERGY_W'(ib) * ENERGY_W'(d));
    endcase
  endfunction : pb_prod

  // ------------------------------------------------------------
  // Per-frame products and cycle boundary
  // ------------------------------------------------------------
  logic signed [ENERGY_W-1:0] prod [3];
  logic signed [ENERGY_W-1:0] sum [3];
  logic [NS_W+1:0] ns_sum;
  logic [NS_W-1:0] ns_mean;
  logic [NS_W:0] pos_inc;
  logic save;
  logic [2:0][RMS_W-1:0] vrms_in;
  logic [2:0][RMS_W-1:0] irms_in;
  logic [2:0][ENERGY_W-1:0] app_e;
  logic [2:0] load_ok;

  assign vrms_in = {phase_rms_voltage_c_i, phase_rms_voltage_b_i, phase_rms_voltage_a_i};
  assign irms_in = {phase_rms_current_c_i, phase_rms_current_b_i, phase_rms_current_a_i};

  // Fractional length: position advances one frame, keeps the remainder
  always_comb begin
    prod[0] = ENERGY_W'(va_i) * ENERGY_W'(ia_i);
    prod[1] = pb_prod(phase_b_connection_field_i, ib_i, vb_i, va_i, vc_i);
    prod[2] = ENERGY_W'(vc_i) * ENERGY_W'(ic_i);
    for (int p = 0; p < 3; p++) begin
      sum[p] = $signed(st_q.acc[p]) + prod[p];
    end
    ns_sum = (NS_W+2)'(cycle_length_frames_a_i) + cycle_length_frames_b_i
             + cycle_length_frames_c_i;
    ns_mean = NS_W'(ns_sum / (NS_W+2)'(3));
    pos_inc = st_q.pos + NS_ONE;
    save = frame_valid_i && (ns_mean != '0) && (pos_inc > {1'b0, ns_mean});
  end

  // Apparent energy and no-load test for the saved cycle
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      app_e[p] = ENERGY_W'(((2*RMS_W)'(st_q.vr[p]) * st_q.ir[p]) >> RMS_W)
                 * st_q.ns[NS_W-1:NS_FRAC];
      load_ok[p] = (no_load_threshold_i == '0) ||
                   ({1'b0, st_q.ir[p]} >= {no_load_threshold_i, {NO_LOAD_THRESHOLD_SHIFT{1'b0}}});
    end
  end

  // ------------------------------------------------------------
  // Divider operands for result slot k
  // ------------------------------------------------------------
  logic [1:0] kp;
  logic [ENERGY_W-1:0] emag;
  logic [DIVD_W-1:0] dvd;
  logic [ENERGY_W-1:0] dvs;
  logic [DIVD_W-1:0] quot;
  logic div_done;
  logic [RESULT_W-1:0] raw;
  logic [RESULT_W-1:0] res_val;
  logic neg;

  always_comb begin
    kp = phase_of(st_q.k);
    emag = mag(st_q.sav[kp]);
    dvs = ENERGY_W'(st_q.ns);
    if (st_q.k < RES_APP) begin
      dvd = DIVD_W'(emag) * DIVD_W'(power_conversion_constant_i);
    end else if (st_q.k < RES_PF) begin
      dvd = DIVD_W'(st_q.app[kp]) * DIVD_W'(power_conversion_constant_i);
    end else if (st_q.k < RES_FREQ) begin
      dvd = DIVD_W'(emag) << PF_SHIFT;
      dvs = st_q.app[kp];
    end else begin
      dvd = (FREQ_SCALE * DIVD_W'(line_cycles_per_dsp_cycle_i)) << NS_FRAC;
    end
    // Length carries fraction bits: power shifts back up, frequency is pre-shifted
    if (dvs == '0) begin
      raw = '0;
    end else if (st_q.k < RES_PF) begin
      raw = RESULT_W'(quot << NS_FRAC);
    end else begin
      raw = quot[RESULT_W-1:0];
    end
    neg = st_q.sav[kp][ENERGY_W-1] &&
          (st_q.k < RES_APP || (st_q.k >= RES_PF && st_q.k < RES_FREQ));
    res_val = neg ? RESULT_W'(-raw) : raw;
  end

  pec_divider #(
    .NW(DIVD_W),
    .DW(ENERGY_W)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .start_i(st_q.div_start),
    .dividend_i(dvd),
    .divisor_i(dvs),
    .done_o(div_done),
    .quotient_o(quot)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic [1:0] dp;
  logic [DATA_W-1:0] val;

  always_comb begin
    st_d = st_q;
    dp = phase_of(disp_sel_i);
    val = '0;
    st_d.done = 1'b0;
    st_d.dvalid = 1'b0;
    st_d.div_start = 1'b0;
    // Postprocessing pass, one divider run per result slot
    case (st_q.pp)
      PP_IDLE: st_d.busy = 1'b0;
      PP_PREP: begin
        for (int p = 0; p < 3; p++) begin
          st_d.app[p] = app_e[p];
          if (!st_q.discard && load_ok[p]) begin
            st_d.tot[p] = st_q.tot[p] + st_q.sav[p];
          end
        end
        st_d.k = '0;
        st_d.pp = PP_START;
      end
      PP_START: begin
        st_d.div_start = 1'b1;
        st_d.pp = PP_WAIT;
      end
      PP_WAIT: begin
        if (div_done) begin
          st_d.work[st_q.k] = res_val;
          st_d.k = st_q.k + 4'h1;
          st_d.pp = (st_q.k == RES_FREQ) ? PP_DONE : PP_START;
        end
      end
      PP_DONE: begin
        // Publish the whole set at once so reads never mix cycles
        st_d.pub = st_q.work;
        st_d.vr_pub = st_q.vr;
        st_d.ir_pub = st_q.ir;
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
        st_d.pp = PP_IDLE;
      end
      default: st_d.pp = PP_IDLE;
    endcase
    // Background accumulation runs regardless of the pass
    if (frame_valid_i) begin
      for (int p = 0; p < 3; p++) begin
        st_d.acc[p] = save ? '0 : sum[p];
        if (save) begin
          st_d.sav[p] = sum[p];
        end
      end
      st_d.pos = save ? pos_inc - {1'b0, ns_mean} : pos_inc;
    end
    // A save during a pass restarts it; pacing is the host's duty
    if (save) begin
      st_d.vr = vrms_in;
      st_d.ir = irms_in;
      st_d.ns = ns_mean;
      st_d.discard = (st_q.delay != '0);
      if (st_q.delay != '0) begin
        st_d.delay = st_q.delay - 1'b1;
      end
      st_d.busy = 1'b1;
      st_d.pp = PP_PREP;
    end
    if (acc_delay_wr_i) begin
      st_d.delay = acc_delay_wdata_i;
    end
    st_d.pulse_en = (st_d.delay == '0);
    // On-demand display values from the published set
    if (disp_req_i) begin
      if (disp_sel_i < SEL_AMP) begin
        val = DATA_W'(st_q.vr_pub[dp]) * DATA_W'(voltage_conversion_constant_i);
      end else if (disp_sel_i < SEL_RESULT) begin
        val = DATA_W'(st_q.ir_pub[dp]) * DATA_W'(current_conversion_constant_i);
      end else begin
        val = DATA_W'($signed(st_q.pub[disp_sel_i - SEL_RESULT]));
      end
      st_d.dout = val & len_mask(disp_len_i);
      st_d.dvalid = 1'b1;
    end
  end

  // Single register for all state; reset loads the delay default
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_q <= '0;
      st_q.delay <= ACC_DELAY_RESET;
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

  assign accumulation_delay_count_o = st_q.delay;
  assign pulse_enable_o = st_q.pulse_en;
  assign postproc_busy_o = st_q.busy;
  assign dsp_cycle_done_o = st_q.done;
  assign disp_valid_o = st_q.dvalid;
  assign disp_data_o = st_q.dout;
  assign active_energy_a_o = st_q.tot[0];
  assign active_energy_b_o = st_q.tot[1];
  assign active_energy_c_o = st_q.tot[2];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  delay_reset_a: assert property (
    $fell(reset_i) |-> accumulation_delay_count_o == ACC_DELAY_RESET)
    else $error("delay count not five after reset");

  pulse_gate_a: assert property (
    pulse_enable_o == (accumulation_delay_count_o == '0))
    else $error("pulse enabled while delay nonzero");

  delay_step_a: assert property (
    save && clk_en_i && !acc_delay_wr_i && accumulation_delay_count_o != '0
    |=> accumulation_delay_count_o == $past(accumulation_delay_count_o) - 8'h01)
    else $error("delay count did not step");

  save_clear_a: assert property (
    save && clk_en_i |=> st_q.acc[0] == '0 && $signed(st_q.sav[0]) == $past(sum[0]))
    else $error("save lost or doubled a sample");

  phase_a_sum_a: assert property (
    frame_valid_i && clk_en_i && !save
    |=> $signed(st_q.acc[0]) == $past($signed(st_q.acc[0]))
        + $past(ENERGY_W'(va_i) * ENERGY_W'(ia_i)))
    else $error("phase a product wrong");

  phase_b_sum_a: assert property (
    frame_valid_i && clk_en_i && !save && phase_b_connection_field_i == CONN_NEG_VC
    |=> $signed(st_q.acc[1]) == $past($signed(st_q.acc[1]))
        - $past(ENERGY_W'(ib_i) * ENERGY_W'(vc_i)))
    else $error("phase b product wrong");

  trigger_a: assert property (
    save && clk_en_i |=> postproc_busy_o && st_q.pp == PP_PREP)
    else $error("save did not start postprocessing");

  no_load_threshold_a: assert property (
    st_q.pp == PP_PREP && clk_en_i && !save && !load_ok[0] |=> $stable(st_q.tot[0]))
    else $error("no-load phase accumulated");

  // Full-length reads only; results sign-extend, RMS products zero-extend
  wide_a: assert property (
    disp_valid_o && ($past(disp_len_i) == '0 || $past(disp_len_i) >= BYTES_FULL)
    |-> disp_data_o[DATA_W-1:RESULT_W] == (($past(disp_sel_i) >= SEL_RESULT) ?
        {(DATA_W-RESULT_W){disp_data_o[RESULT_W-1]}} : '0))
    else $error("display value wider than 48 bits");

  short_len_a: assert property (
    disp_req_i && clk_en_i && disp_len_i == 4'h4 |=> disp_valid_o && disp_data_o[63:32] == '0)
    else $error("short read not masked");

  save_c: cover property (save && clk_en_i);
  pass_c: cover property (st_q.pp == PP_DONE && clk_en_i);
  expire_c: cover property ($fell(pulse_enable_o == 1'b0));
  short_c: cover property (disp_req_i && disp_len_i == 4'h4);

endmodule : pec_energy_compute

/* File: design/pec_pkg.sv */
// Shared constants for the polyphase energy computation block
package pec_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int ENERGY_W = 48;
  localparam int RMS_W = 32;
  localparam int CC_W = 16;
  localparam int NS_W = 24;
  localparam int NS_FRAC = 8;
  localparam int CYC_W = 8;
  localparam int DELAY_W = 8;
  localparam int NO_LOAD_THRESHOLD_W = 17;
  localparam int RESULT_W = 48;
  localparam int DATA_W = 64;
  localparam int LEN_W = 4;
  localparam int SEL_W = 4;
  localparam int DIVD_W = 64;

  // ------------------------------------------------------------
  // Reset values and scaling
  // ------------------------------------------------------------
  localparam logic [DELAY_W-1:0] ACC_DELAY_RESET = 8'h05;
  localparam int NO_LOAD_THRESHOLD_SHIFT = 16;
  localparam int PF_SHIFT = 14;
  localparam logic [LEN_W-1:0] BYTES_FULL = 4'h8;
  localparam logic [NS_W:0] NS_ONE = (NS_W+1)'(1) << NS_FRAC;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam longint FRAME_PERIOD_NS = 320000;
  localparam longint MILLIHZ_NS = 64'd1000000000000;
  localparam logic [DIVD_W-1:0] FREQ_SCALE = DIVD_W'(MILLIHZ_NS / FRAME_PERIOD_NS);

  // ------------------------------------------------------------
  // Phase B connection codes
  // ------------------------------------------------------------
  localparam logic [1:0] CONN_VB = 2'h0;
  localparam logic [1:0] CONN_NEG_VC = 2'h1;
  localparam logic [1:0] CONN_NEG_SUM = 2'h2;
  localparam logic [1:0] CONN_NEG_DIFF = 2'h3;

  // ------------------------------------------------------------
  // Result slots and display selects
  // ------------------------------------------------------------
  localparam logic [3:0] RES_APP = 4'h3;
  localparam logic [3:0] RES_PF = 4'h6;
  localparam logic [3:0] RES_FREQ = 4'h9;
  localparam int RES_COUNT = 10;
  localparam logic [SEL_W-1:0] SEL_AMP = 4'h3;
  localparam logic [SEL_W-1:0] SEL_RESULT = 4'h6;

endpackage : pec_pkg

/* File: dv/pec_energy_compute_tb_top.sv */
// Self-checking bench for the energy computation block
`timescale 1ns/1ps
module pec_energy_compute_tb_top;
  import pec_pkg::*;
  logic clk_sys_i = 0;
  logic reset_i = 1;
  logic clk_en = 1;
  logic req = 0;
  logic wr = 0;
  logic fv, pe, busy, done, dv;
  logic [95:0] smp_drv, smp;
  logic [1:0] conn;
  logic [16:0] thr;
  logic [31:0] rms [6];
  logic [15:0] vcc, acc;
  logic [7:0] wdata, cnt;
  logic [3:0] sel, len;
  logic [63:0] dd, mask;
  logic [47:0] ea, eb, ec;
  logic signed [47:0] pa, pb, pc, da, db, dc;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int f [4] = '{1, -1, -2, 0};

  pec_frame_source pec_frame_source_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .samples_i(smp_drv), .frame_valid_o(fv), .samples_o(smp));

  pec_energy_compute pec_energy_compute_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .clk_en_i(clk_en), .frame_valid_i(fv), .va_i(smp[95:80]), .vb_i(smp[79:64]),
    .vc_i(smp[63:48]), .ia_i(smp[47:32]), .ib_i(smp[31:16]), .ic_i(smp[15:0]),
    .phase_b_connection_field_i(conn), .cycle_length_frames_a_i(24'h000300),
    .cycle_length_frames_b_i(24'h000400), .cycle_length_frames_c_i(24'h000500),
    .line_cycles_per_dsp_cycle_i(8'h02), .phase_rms_voltage_a_i(rms[0]),
    .phase_rms_voltage_b_i(rms[1]), .phase_rms_voltage_c_i(rms[2]),
    .phase_rms_current_a_i(rms[3]), .phase_rms_current_b_i(rms[4]),
    .phase_rms_current_c_i(rms[5]), .no_load_threshold_i(thr),
    .voltage_conversion_constant_i(vcc), .current_conversion_constant_i(acc),
    .power_conversion_constant_i(16'h0368), .acc_delay_wr_i(wr),
    .acc_delay_wdata_i(wdata), .disp_req_i(req), .disp_sel_i(sel), .disp_len_i(len),
    .accumulation_delay_count_o(cnt), .pulse_enable_o(pe), .postproc_busy_o(busy),
    .dsp_cycle_done_o(done), .disp_valid_o(dv), .disp_data_o(dd),
    .active_energy_a_o(ea), .active_energy_b_o(eb), .active_energy_c_o(ec));

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // About 18 passes of 800 cycles are expected
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits for a published pass, then takes per-cycle energy deltas
  task automatic wait_done();
    int n;
    logic sb;
    n = 0;
    sb = 1'b0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (busy === 1'b1) begin
        sb = 1'b1;
      end
    end while (done !== 1'b1 && n < 3000);
    chk({63'h0, n >= 3000}, 64'h0);
    chk({63'h0, sb}, 64'h1);
    chk({63'h0, busy}, 64'h0);
    da = ea - pa;
    db = eb - pb;
    dc = ec - pc;
    pa = ea;
    pb = eb;
    pc = ec;
  endtask : wait_done

  task automatic disp(input logic [3:0] s, input logic [3:0] l, input logic [63:0] exp);
    @(posedge clk_sys_i);
    #1;
    req = 1;
    sel = s;
    len = l;
    @(posedge clk_sys_i);
    #1;
    req = 0;
    chk({63'h0, dv}, 64'h1);
    chk(dd, exp);
  endtask : disp

  task automatic wr_delay(input logic [7:0] v);
    @(posedge clk_sys_i);
    #1;
    wr = 1;
    wdata = v;
    @(posedge clk_sys_i);
    #1;
    wr = 0;
  endtask : wr_delay

  task automatic finish_test();
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    smp_drv = {{3{16'h0004}}, {3{16'h0005}}};
    conn = 2'h0;
    thr = 17'h0;
    rms = '{32'h1234_5678, 32'h0ab0_cdef, 32'h00c0_ffee,
            32'h0002_0000, 32'h0003_1234, 32'h0004_5678};
    vcc = 16'h0abc;
    acc = 16'h1357;
    wdata = 8'h0;
    sel = 4'h0;
    len = 4'h0;
    {pa, pb, pc} = '0;
    repeat (5) @(posedge clk_sys_i);
    #1;
    reset_i = 0;
    chk(cnt, 8'h05);
    chk(pe, 1'b0);
    disp(4'h0, 4'h0, 64'h0);
    wait_done();
    chk(cnt, 8'h04);
    chk(ea, 48'h0);
    wr_delay(8'h00);
    chk(pe, 1'b1);
    wait_done();
    // Each mode gets one clean cycle after a mixed one
    for (int k = 0; k < 4; k++) begin
      conn = k[1:0];
      wait_done();
      wait_done();
      chk({63'h0, da === '0}, 64'h0);
      chk(dc, da);
      chk(db, f[k] * da);
    end
    // Just below and exactly at the smallest nonzero threshold
    thr = 17'h1;
    rms[3] = 32'h0000_ffff;
    wait_done();
    wait_done();
    chk(da, 48'h0);
    chk({63'h0, dc === '0}, 64'h0);
    rms[3] = 32'h0001_0000;
    wait_done();
    wait_done();
    chk({63'h0, da === '0}, 64'h0);
    thr = 17'h0;
    rms[3] = 32'h0000_0001;
    wait_done();
    wait_done();
    chk({63'h0, da === '0}, 64'h0);
    wr_delay(8'h01);
    chk(pe, 1'b0);
    wait_done();
    chk(da, 48'h0);
    chk(cnt, 8'h00);
    chk(pe, 1'b1);
    wait_done();
    chk({63'h0, da === '0}, 64'h0);
    // Clock enable low: a write must not land
    clk_en = 0;
    wr_delay(8'h03);
    chk(cnt, 8'h00);
    chk(pe, 1'b1);
    clk_en = 1;
    // Length equals select here, so 0 gives all eight bytes
    for (int s = 0; s < 6; s++) begin
      mask = (s == 0) ? '1 : (64'h1 << (8 * s)) - 64'h1;
      disp(s[3:0], s[3:0], (64'(rms[s]) * (s < 3 ? vcc : acc)) & mask);
    end
    disp(4'hf, 4'h8, 64'd1562500);
    finish_test();
  end
endmodule : pec_energy_compute_tb_top

/* File: dv/pec_frame_source.sv */
// Frame source model: paced sample frames for the energy block
`timescale 1ns/1ps
module pec_frame_source #(
  parameter int PERIOD = 200
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [95:0] samples_i,
  output logic frame_valid_o,
  output logic [95:0] samples_o
);
  int cnt_q;
  // ------------------------------------------------------------
  // Frame pacing
  // ------------------------------------------------------------
  // Spacing chosen so each pass ends well before the next save
  always @(posedge clk_sys_i) begin
    if (reset_i || cnt_q == PERIOD - 1) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  // One pulse per frame; lines carry inverted data between frames
  assign frame_valid_o = !reset_i && cnt_q == PERIOD - 1;
  assign samples_o = frame_valid_o ? samples_i : ~samples_i;
endmodule : pec_frame_source
